// ### design/oag_pkg.sv
// package: operand modes, fsm states and address helpers
package oag_pkg;

  localparam int RF_AW = 12;
  localparam int PM_AW = 16;
  localparam int DW    = 8;

  // upper nibble that marks the escaped working-register window
  localparam logic [3:0]       ESC_NIBBLE  = 4'hE;
  // odd partner of an even pair address
  localparam logic [RF_AW-1:0] PAIR_LO_BIT = 12'h001;

  typedef enum logic [3:0] {
    OAG_M_IMM           = 4'h0,
    OAG_M_WREG          = 4'h1,
    OAG_M_WPAIR         = 4'h2,
    OAG_M_REG           = 4'h3,
    OAG_M_REGPAIR       = 4'h4,
    OAG_M_IND_WREG      = 4'h5,
    OAG_M_IND_WPAIR_RF  = 4'h6,
    OAG_M_IND_WPAIR_PM  = 4'h7,
    OAG_M_IND_REG       = 4'h8,
    OAG_M_IND_REGPAIR   = 4'h9,
    OAG_M_INDEXED       = 4'hA,
    OAG_M_JP_ABS        = 4'hB,
    OAG_M_JP_REL        = 4'hC
  } oag_mode_t;

  typedef enum logic [4:0] {
    OAG_ST_IDLE  = 5'h01,
    OAG_ST_ISSUE = 5'h02,
    OAG_ST_WAIT  = 5'h04,
    OAG_ST_CAP   = 5'h08,
    OAG_ST_DONE  = 5'h10
  } oag_state_t;

  function automatic logic [3:0] rp_lo(input logic [7:0] rp);
    return rp[3:0];
  endfunction

  function automatic logic [3:0] rp_hi(input logic [7:0] rp);
    return rp[7:4];
  endfunction

  function automatic logic is_escaped(input logic [7:0] a);
    return a[7:4] == ESC_NIBBLE;
  endfunction

  function automatic logic [3:0] low_nib(input logic [7:0] a);
    return a[3:0];
  endfunction

  function automatic logic uses_work(input oag_mode_t m);
    return m inside {OAG_M_WREG, OAG_M_WPAIR, OAG_M_IND_WREG,
                     OAG_M_IND_WPAIR_RF, OAG_M_IND_WPAIR_PM, OAG_M_INDEXED};
  endfunction

  function automatic logic work_is_pair(input oag_mode_t m);
    return m inside {OAG_M_WPAIR, OAG_M_IND_WPAIR_RF, OAG_M_IND_WPAIR_PM};
  endfunction

endpackage

// ### design/oag_map_if.sv
// interface: register window mapper request and result
`timescale 1ns/10ps
interface oag_map_if;
  logic [7:0]  rp;
  logic        use_work;
  logic        pair;
  logic [3:0]  wnum;
  logic [7:0]  addr8;
  logic [11:0] addr12;
  modport core   (output rp, use_work, pair, wnum, addr8, input addr12);
  modport mapper (input rp, use_work, pair, wnum, addr8, output addr12);
endinterface

// ### design/oag_map.sv
// register window mapper: 4-bit and 8-bit names to 12-bit addresses
`timescale 1ns/10ps
module oag_map
  import oag_pkg::*;
(
  // request and result
  oag_map_if.mapper m
);

  logic [3:0] wn;

  always_comb begin
    // pairs live on even numbers, odd request bit is dropped
    wn = m.pair ? {m.wnum[3:1], 1'b0} : m.wnum;
    if (m.use_work) begin
      m.addr12 = {rp_lo(m.rp), rp_hi(m.rp), wn};
    end else if (is_escaped(m.addr8)) begin
      m.addr12 = {rp_lo(m.rp), rp_hi(m.rp), low_nib(m.addr8)};
    end else begin
      m.addr12 = {rp_lo(m.rp), m.addr8};
    end
  end

endmodule // oag_map

// ### design/oag_addr_gen.sv
// operand address generator: sequencer, operand reads and jump targets
// Summary of operation
// - working register address: pointer low, pointer high, number
// - working pair uses even numbers only, same pointer nibble prefix
// - register 00h-DFh or F0h-FFh maps to pointer low then the address
// - escaped E0h-EFh maps to pointer low, high, address low nibble
// - escaped and normal mapping apply to register pairs as well
// - indirect working register: its byte, prefixed by pointer low nibble
// - indirect working pair gives 12-bit file or 16-bit program address
// - indirect register: fetched byte prefixed by pointer low nibble
// - indirect register pair gives a 16-bit program address
// - indexed: base plus signed register offset, pointer low prefix
// - absolute jump loads program counter with the 16-bit target
// - conditional jumps carry a 4-bit condition field to the flag test
`timescale 1ns/10ps
module oag_addr_gen
  import oag_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // operand request from decode
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire oag_mode_t         req_mode,
  input  wire logic [7:0]        reg_window_pointer,
  input  wire logic [3:0]        work_reg_n,
  input  wire logic [7:0]        reg_addr8,
  input  wire logic [PM_AW-1:0]  direct_jump_target,
  input  wire logic [7:0]        relative_jump_offset,
  input  wire logic [PM_AW-1:0]  next_pc,
  input  wire logic [3:0]        condition_field,
  // operand result
  output logic                   done,
  output logic [RF_AW-1:0]       rf_addr,
  output logic [PM_AW-1:0]       pm_addr,
  output logic [DW-1:0]          immediate_operand,
  output logic                   pc_load,
  output logic [PM_AW-1:0]       new_pc,
  output logic [3:0]             cond_out,
  // register file read port, data one cycle after enable
  output logic                   rf_rd_en,
  output logic [RF_AW-1:0]       rf_rd_addr,
  input  wire logic [DW-1:0]     rf_rd_data,
  // program memory read port, data one cycle after enable
  output logic                   pm_rd_en,
  output logic [PM_AW-1:0]       pm_rd_addr,
  input  wire logic [DW-1:0]     pm_rd_data
);

  oag_state_t        state_r,   state_nxt;
  oag_mode_t         mode_r,    mode_nxt;
  logic [7:0]        rp_r,      rp_nxt;
  logic [3:0]        wn_r,      wn_nxt;
  logic [7:0]        a8_r,      a8_nxt;
  logic [PM_AW-1:0]  tgt_r,     tgt_nxt;
  logic [7:0]        off_r,     off_nxt;
  logic [PM_AW-1:0]  npc_r,     npc_nxt;
  logic [3:0]        cc_r,      cc_nxt;
  logic [DW-1:0]     hi_r,      hi_nxt;
  logic              second_r,  second_nxt;
  logic [RF_AW-1:0]  rfa_r,     rfa_nxt;
  logic [PM_AW-1:0]  pma_r,     pma_nxt;
  logic [DW-1:0]     imm_r,     imm_nxt;
  logic              pcl_r,     pcl_nxt;
  logic [PM_AW-1:0]  npcq_r,    npcq_nxt;
  logic              rfen_r,    rfen_nxt;
  logic [RF_AW-1:0]  rfra_r,    rfra_nxt;
  logic              pmen_r,    pmen_nxt;
  logic [PM_AW-1:0]  pmra_r,    pmra_nxt;

  oag_map_if mif ();

  oag_map u_map (
    .m (mif.mapper)
  );

  // mapper sees only captured operands, so no input path reaches it
  assign mif.rp       = rp_r;
  assign mif.use_work = uses_work(mode_r);
  assign mif.pair     = work_is_pair(mode_r);
  assign mif.wnum     = wn_r;
  assign mif.addr8    = a8_r;

  assign req_ready         = (state_r == OAG_ST_IDLE);
  assign done              = (state_r == OAG_ST_DONE);
  assign rf_addr           = rfa_r;
  assign pm_addr           = pma_r;
  assign immediate_operand = imm_r;
  assign pc_load           = pcl_r;
  assign new_pc            = npcq_r;
  assign cond_out          = cc_r;
  assign rf_rd_en          = rfen_r;
  assign rf_rd_addr        = rfra_r;
  assign pm_rd_en          = pmen_r;
  assign pm_rd_addr        = pmra_r;

  always_comb begin
    state_nxt  = state_r;
    mode_nxt   = mode_r;
    rp_nxt     = rp_r;
    wn_nxt     = wn_r;
    a8_nxt     = a8_r;
    tgt_nxt    = tgt_r;
    off_nxt    = off_r;
    npc_nxt    = npc_r;
    cc_nxt     = cc_r;
    hi_nxt     = hi_r;
    second_nxt = second_r;
    rfa_nxt    = rfa_r;
    pma_nxt    = pma_r;
    imm_nxt    = imm_r;
    npcq_nxt   = npcq_r;
    rfra_nxt   = rfra_r;
    pmra_nxt   = pmra_r;
    pcl_nxt    = 1'b0;
    rfen_nxt   = 1'b0;
    pmen_nxt   = 1'b0;
    unique case (state_r)
      OAG_ST_IDLE: begin
        if (req_valid) begin
          mode_nxt   = req_mode;
          rp_nxt     = reg_window_pointer;
          wn_nxt     = work_reg_n;
          a8_nxt     = reg_addr8;
          tgt_nxt    = direct_jump_target;
          off_nxt    = relative_jump_offset;
          npc_nxt    = next_pc;
          cc_nxt     = condition_field;
          second_nxt = 1'b0;
          state_nxt  = OAG_ST_ISSUE;
        end
      end
      OAG_ST_ISSUE: begin
        state_nxt = OAG_ST_WAIT;
        unique case (mode_r)
          OAG_M_IMM: begin
            pmen_nxt = 1'b1;
            pmra_nxt = npc_r;
          end
          OAG_M_WREG, OAG_M_WPAIR, OAG_M_REG, OAG_M_REGPAIR: begin
            rfa_nxt   = mif.addr12;
            state_nxt = OAG_ST_DONE;
          end
          OAG_M_JP_ABS: begin
            npcq_nxt  = tgt_r;
            pcl_nxt   = 1'b1;
            state_nxt = OAG_ST_DONE;
          end
          OAG_M_JP_REL: begin
            npcq_nxt  = npc_r + {{8{off_r[7]}}, off_r};
            pcl_nxt   = 1'b1;
            state_nxt = OAG_ST_DONE;
          end
          default: begin
            rfen_nxt = 1'b1;
            rfra_nxt = mif.addr12;
          end
        endcase
      end
      OAG_ST_WAIT: begin
        state_nxt = OAG_ST_CAP;
      end
      OAG_ST_CAP: begin
        state_nxt = OAG_ST_DONE;
        unique case (mode_r)
          OAG_M_IMM: begin
            imm_nxt = pm_rd_data;
          end
          OAG_M_IND_WREG, OAG_M_IND_REG: begin
            rfa_nxt = {rp_lo(rp_r), rf_rd_data};
          end
          OAG_M_INDEXED: begin
            // signed offset: 8-bit wrap equals two's complement add
            rfa_nxt = {rp_lo(rp_r), 8'(a8_r + rf_rd_data)};
          end
          default: begin
            if (!second_r) begin
              hi_nxt     = rf_rd_data;
              second_nxt = 1'b1;
              rfen_nxt   = 1'b1;
              rfra_nxt   = rfra_r | PAIR_LO_BIT;
              state_nxt  = OAG_ST_WAIT;
            end else if (mode_r == OAG_M_IND_WPAIR_RF) begin
              rfa_nxt = {rp_lo(hi_r), rf_rd_data};
            end else begin
              pma_nxt = {hi_r, rf_rd_data};
            end
          end
        endcase
      end
      OAG_ST_DONE: begin
        state_nxt = OAG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= OAG_ST_IDLE;
      mode_r   <= OAG_M_IMM;
      rp_r     <= 8'h00;
      wn_r     <= 4'h0;
      a8_r     <= 8'h00;
      tgt_r    <= 16'h0000;
      off_r    <= 8'h00;
      npc_r    <= 16'h0000;
      cc_r     <= 4'h0;
      hi_r     <= 8'h00;
      second_r <= 1'b0;
      rfa_r    <= 12'h000;
      pma_r    <= 16'h0000;
      imm_r    <= 8'h00;
      pcl_r    <= 1'b0;
      npcq_r   <= 16'h0000;
      rfen_r   <= 1'b0;
      rfra_r   <= 12'h000;
      pmen_r   <= 1'b0;
      pmra_r   <= 16'h0000;
    end else begin
      state_r  <= state_nxt;
      mode_r   <= mode_nxt;
      rp_r     <= rp_nxt;
      wn_r     <= wn_nxt;
      a8_r     <= a8_nxt;
      tgt_r    <= tgt_nxt;
      off_r    <= off_nxt;
      npc_r    <= npc_nxt;
      cc_r     <= cc_nxt;
      hi_r     <= hi_nxt;
      second_r <= second_nxt;
      rfa_r    <= rfa_nxt;
      pma_r    <= pma_nxt;
      imm_r    <= imm_nxt;
      pcl_r    <= pcl_nxt;
      npcq_r   <= npcq_nxt;
      rfen_r   <= rfen_nxt;
      rfra_r   <= rfra_nxt;
      pmen_r   <= pmen_nxt;
      pmra_r   <= pmra_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_imm_fetch;
    (state_r == OAG_ST_ISSUE && mode_r == OAG_M_IMM) |->
      ##1 (pm_rd_en && pm_rd_addr == npc_r)
      ##2 (done && immediate_operand == $past(pm_rd_data));
  endproperty
  a_imm_fetch: assert property (p_imm_fetch)
    else $error("immediate not taken from byte after opcode");

  property p_wreg_map;
    (state_r == OAG_ST_ISSUE && mode_r == OAG_M_WREG) |=>
      (done && rf_addr == {rp_lo(rp_r), rp_hi(rp_r), wn_r});
  endproperty
  a_wreg_map: assert property (p_wreg_map)
    else $error("working register address wrong");

  property p_wpair_even;
    (state_r == OAG_ST_ISSUE && mode_r == OAG_M_WPAIR) |=>
      (rf_addr[0] == 1'b0 &&
       rf_addr[RF_AW-1:4] == {rp_lo(rp_r), rp_hi(rp_r)});
  endproperty
  a_wpair_even: assert property (p_wpair_even)
    else $error("working pair address not even or wrong prefix");

  property p_reg_normal;
    (state_r == OAG_ST_ISSUE && !is_escaped(a8_r) &&
     (mode_r == OAG_M_REG || mode_r == OAG_M_REGPAIR)) |=>
      (rf_addr == {rp_lo(rp_r), a8_r});
  endproperty
  a_reg_normal: assert property (p_reg_normal)
    else $error("normal register address wrong");

  property p_reg_escaped;
    (state_r == OAG_ST_ISSUE && is_escaped(a8_r) &&
     (mode_r == OAG_M_REG || mode_r == OAG_M_REGPAIR)) |=>
      (rf_addr == {rp_lo(rp_r), rp_hi(rp_r), low_nib(a8_r)});
  endproperty
  a_reg_escaped: assert property (p_reg_escaped)
    else $error("escaped register address wrong");

  property p_ind_byte;
    (state_r == OAG_ST_CAP &&
     (mode_r == OAG_M_IND_WREG || mode_r == OAG_M_IND_REG)) |=>
      (done && rf_addr == {rp_lo(rp_r), $past(rf_rd_data)});
  endproperty
  a_ind_byte: assert property (p_ind_byte)
    else $error("indirect effective address wrong");

  property p_pair_pm;
    (state_r == OAG_ST_CAP && second_r &&
     (mode_r == OAG_M_IND_WPAIR_PM || mode_r == OAG_M_IND_REGPAIR)) |=>
      (done && pm_addr == {$past(hi_r), $past(rf_rd_data)});
  endproperty
  a_pair_pm: assert property (p_pair_pm)
    else $error("pair program address wrong");

  property p_indexed;
    (state_r == OAG_ST_CAP && mode_r == OAG_M_INDEXED) |=>
      (rf_addr == {rp_lo(rp_r), 8'($past(a8_r) + $past(rf_rd_data))});
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed address wrong");

  property p_jp_abs;
    (state_r == OAG_ST_ISSUE && mode_r == OAG_M_JP_ABS) |=>
      (pc_load && done && new_pc == $past(tgt_r));
  endproperty
  a_jp_abs: assert property (p_jp_abs)
    else $error("absolute target not loaded");

  property p_jp_rel;
    (state_r == OAG_ST_ISSUE && mode_r == OAG_M_JP_REL) |=>
      (pc_load && new_pc == 16'($past(npc_r) +
                  {{8{$past(off_r[7])}}, $past(off_r)}));
  endproperty
  a_jp_rel: assert property (p_jp_rel)
    else $error("relative target wrong");

  property p_cond;
    (req_valid && req_ready) |=> (cond_out == $past(condition_field));
  endproperty
  a_cond: assert property (p_cond)
    else $error("condition field not carried");

  property p_pair_order;
    (state_r == OAG_ST_CAP && !second_r && work_is_pair(mode_r)) |=>
      (rf_rd_en && rf_rd_addr == ($past(rf_rd_addr) | PAIR_LO_BIT));
  endproperty
  a_pair_order: assert property (p_pair_order)
    else $error("low byte not read from odd address");

endmodule // oag_addr_gen

// ### verification/oag_mem_model.sv
// register file and program memory model with one cycle read latency
`timescale 1ns/10ps
module oag_mem_model
  import oag_pkg::*;
(
  // clock
  input  wire logic             sys_clk,
  // register file read port
  input  wire logic             rf_rd_en,
  input  wire logic [RF_AW-1:0] rf_rd_addr,
  output logic      [DW-1:0]    rf_rd_data,
  // program memory read port
  input  wire logic             pm_rd_en,
  input  wire logic [PM_AW-1:0] pm_rd_addr,
  output logic      [DW-1:0]    pm_rd_data
);
  initial begin
    rf_rd_data = 8'h00;
    pm_rd_data = 8'h00;
  end
  // idle cycles invert the bus so stale data never passes as a fresh read
  always @(posedge sys_clk) begin
    if (rf_rd_en) begin
      rf_rd_data <= rf_rd_addr[7:0] ^ {rf_rd_addr[11:8], 4'h5};
    end else begin
      rf_rd_data <= ~rf_rd_data;
    end
    if (pm_rd_en) begin
      pm_rd_data <= pm_rd_addr[7:0] ^ pm_rd_addr[15:8];
    end else begin
      pm_rd_data <= ~pm_rd_data;
    end
  end
endmodule // oag_mem_model

// ### verification/tb_top.sv
// self-checking bench for the operand address generator
`timescale 1ns/10ps
module tb_top;
  import oag_pkg::*;
  logic             sys_clk, rst_n, req_valid, req_ready, done, pc_load;
  logic             rf_rd_en, pm_rd_en;
  oag_mode_t        req_mode;
  logic [7:0]       rp, a8, off, imm, rfd, pmd;
  logic [3:0]       wn, cnd, cond_out;
  logic [15:0]      da, npc, pm_addr, new_pc, pm_rd_addr;
  logic [11:0]      rf_addr, rf_rd_addr;
  int               failures = 0;
  int               checked = 0;

  oag_addr_gen oag_addr_gen_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_mode(req_mode), .reg_window_pointer(rp),
    .work_reg_n(wn), .reg_addr8(a8), .direct_jump_target(da),
    .relative_jump_offset(off), .next_pc(npc), .condition_field(cnd),
    .done(done), .rf_addr(rf_addr), .pm_addr(pm_addr),
    .immediate_operand(imm), .pc_load(pc_load), .new_pc(new_pc),
    .cond_out(cond_out), .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
    .rf_rd_data(rfd), .pm_rd_en(pm_rd_en), .pm_rd_addr(pm_rd_addr),
    .pm_rd_data(pmd));

  oag_mem_model oag_mem_model_inst (
    .sys_clk(sys_clk), .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
    .rf_rd_data(rfd), .pm_rd_en(pm_rd_en), .pm_rd_addr(pm_rd_addr),
    .pm_rd_data(pmd));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // memory contents as the model holds them, and the working and register address maps
  function automatic logic [7:0] rfv(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction
  function automatic logic [7:0] pmv(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [11:0] wmap(input logic [7:0] p,
                                       input logic [3:0] n);
    return {p[3:0], p[7:4], n};
  endfunction
  function automatic logic [11:0] rmap(input logic [7:0] p,
                                       input logic [7:0] a);
    return (a[7:4] == 4'hE) ? {p[3:0], p[7:4], a[3:0]} : {p[3:0], a};
  endfunction

  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // one request, held until the take edge, then latency and pulse checks
  task automatic run(input oag_mode_t m, input logic [7:0] p, a, o,
                     input logic [3:0] n, c, input logic [15:0] d, pc);
    int cyc;
    int lat;
    lat = (m inside {OAG_M_IMM, OAG_M_IND_WREG, OAG_M_IND_REG,
                     OAG_M_INDEXED}) ? 4 :
          (m inside {OAG_M_IND_WPAIR_RF, OAG_M_IND_WPAIR_PM,
                     OAG_M_IND_REGPAIR}) ? 6 : 2;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_mode  <= m;
    rp        <= p;
    a8        <= a;
    off       <= o;
    wn        <= n;
    cnd       <= c;
    da        <= d;
    npc       <= pc;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    chk_bit(req_ready, 1'b0);
    // the take edge counts as the first cycle of the answer latency
    cyc = 1;
    do begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end while (done !== 1'b1 && cyc < 12);
    if (cyc == 12) begin
      failures++;
      $display("[ERR] %0t no done", $time);
      tally_and_finish();
    end
    chk_val(16'(cyc), 16'(lat));
    chk_bit(pc_load, m inside {OAG_M_JP_ABS, OAG_M_JP_REL});
    @(posedge sys_clk);
    #1;
    chk_bit(done, 1'b0);
    chk_bit(req_ready, 1'b1);
  endtask

  task automatic t_imm();
    run(OAG_M_IMM, 8'h12, 8'h00, 8'h00, 4'h0, 4'h0, 16'h0000, 16'h00FF);
    chk_val(16'(imm), 16'h00FF);
    run(OAG_M_IMM, 8'h12, 8'h00, 8'h00, 4'h0, 4'h0, 16'h0000, 16'h1212);
    chk_val(16'(imm), 16'(pmv(16'h1212)));
  endtask

  task automatic t_work();
    run(OAG_M_WREG, 8'h3C, 8'h00, 8'h00, 4'hF, 4'h0, 16'h0000, 16'h0000);
    chk_val(16'(rf_addr), 16'h0C3F);
    run(OAG_M_WPAIR, 8'h3C, 8'h00, 8'h00, 4'hD, 4'h0, 16'h0000, 16'h0000);
    chk_val(16'(rf_addr), 16'h0C3C);
  endtask

  task automatic t_reg();
    logic [7:0] tbl [6] = '{8'h00, 8'hDF, 8'hE0, 8'hEF, 8'hF0, 8'hFF};
    logic [11:0] e;
    for (int i = 0; i < 12; i++) begin
      e = rmap(8'hA7, tbl[i % 6]);
      run(i < 6 ? OAG_M_REG : OAG_M_REGPAIR, 8'hA7, tbl[i % 6], 8'h00,
          4'h0, 4'h0, 16'h0000, 16'h0000);
      chk_val(16'(rf_addr), 16'(e));
    end
  endtask

  task automatic t_ind();
    run(OAG_M_IND_WREG, 8'h59, 8'h00, 8'h00, 4'h7, 4'h0, 16'h0000, 16'h0000);
    chk_val(16'(rf_addr), 16'({4'h9, rfv(wmap(8'h59, 4'h7))}));
    run(OAG_M_IND_REG, 8'h59, 8'hE3, 8'h00, 4'h0, 4'h0, 16'h0000, 16'h0000);
    chk_val(16'(rf_addr), 16'({4'h9, rfv(rmap(8'h59, 8'hE3))}));
    run(OAG_M_IND_REG, 8'h59, 8'h25, 8'h00, 4'h0, 4'h0, 16'h0000, 16'h0000);
    chk_val(16'(rf_addr), 16'({4'h9, rfv(rmap(8'h59, 8'h25))}));
  endtask

  task automatic t_pair();
    logic [11:0] pa;
    logic [11:0] pb;
    logic [7:0]  hi;
    pa = wmap(8'h6B, 4'h4);
    pb = rmap(8'h6B, 8'hE6);
    hi = rfv(pa);
    run(OAG_M_IND_WPAIR_RF, 8'h6B, 8'h00, 8'h00, 4'h5, 4'h0, 16'h0, 16'h0);
    chk_val(16'({hi[3:0], rfv(pa | 12'h001)}), 16'(rf_addr));
    run(OAG_M_IND_WPAIR_PM, 8'h6B, 8'h00, 8'h00, 4'h4, 4'h0, 16'h0, 16'h0);
    chk_val(pm_addr, {rfv(pa), rfv(pa | 12'h001)});
    run(OAG_M_IND_REGPAIR, 8'h6B, 8'hE6, 8'h00, 4'h0, 4'h0, 16'h0, 16'h0);
    chk_val(pm_addr, {rfv(pb), rfv(pb | 12'h001)});
  endtask

  task automatic t_idx();
    logic [7:0] o;
    for (int n = 2; n < 12; n += 7) begin
      o = rfv(wmap(8'hC1, 4'(n)));
      run(OAG_M_INDEXED, 8'hC1, 8'hF0, 8'h00, 4'(n), 4'h0, 16'h0, 16'h0);
      chk_val(16'(rf_addr), 16'({4'h1, 8'(8'hF0 + o)}));
    end
  endtask

  task automatic t_jump();
    logic [7:0] o;
    run(OAG_M_JP_ABS, 8'h00, 8'h00, 8'h00, 4'h0, 4'h0, 16'hFFFF, 16'h0);
    chk_val(new_pc, 16'hFFFF);
    run(OAG_M_JP_ABS, 8'h00, 8'h00, 8'h00, 4'h0, 4'h0, 16'h0000, 16'h5);
    chk_val(new_pc, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      o = c[0] ? 8'h80 : 8'h7F;
      run(OAG_M_JP_REL, 8'h00, 8'h00, o, 4'h0, 4'(c), 16'h0, 16'hFFF0);
      chk_val(new_pc, c[0] ? 16'hFF70 : 16'h006F);
      chk_val(16'(cond_out), 16'(c));
    end
  endtask

  // reset while idle after a jump clears held results, then a request is served again
  task automatic t_reset();
    run(OAG_M_JP_ABS, 8'h00, 8'h00, 8'h00, 4'h0, 4'h9, 16'h1234, 16'h0);
    chk_val(new_pc, 16'h1234);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_bit(req_ready, 1'b1);
    chk_bit(done, 1'b0);
    chk_bit(pc_load, 1'b0);
    chk_val(new_pc, 16'h0000);
    chk_val(pm_addr, 16'h0000);
    chk_val(16'(rf_addr), 16'h0000);
    chk_val(16'(cond_out), 16'h0000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    run(OAG_M_WREG, 8'h5A, 8'h00, 8'h00, 4'h3, 4'h0, 16'h0000, 16'h0000);
    chk_val(16'(rf_addr), 16'h0A53);
  endtask

  initial begin
    rst_n     = 1'b0;
    req_valid = 1'b0;
    req_mode  = OAG_M_IMM;
    rp        = 8'h00;
    a8        = 8'h00;
    off       = 8'h00;
    wn        = 4'h0;
    cnd       = 4'h0;
    da        = 16'h0000;
    npc       = 16'h0000;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk_bit(req_ready, 1'b1);
    chk_bit(done, 1'b0);
    t_imm();
    t_work();
    t_reg();
    t_ind();
    t_pair();
    t_idx();
    t_jump();
    t_reset();
    tally_and_finish();
  end
endmodule // tb_top
